//--- inc/mas_params.svh
// Constants of the memory access sequencer: offsets, field positions, timing.
// Included by every design file; definitions only.
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH

`define CLK_PERIOD_NS 5
`define MEM_CYCLE_NS 4000
`define MEM_CYCLE_CLKS ((`MEM_CYCLE_NS) / (`CLK_PERIOD_NS))

`define NUM_CH 13
`define NUM_CW 4
`define NIBS_PER_WORD 7

`define F_IND 24
`define F_SIGN 24
`define F_IX_HI 23
`define F_IX_LO 20
`define F_FS_HI 19
`define F_FS_LO 15
`define F_AR_HI 13
`define F_AR_LO 10
`define F_M_HI 9
`define F_WC_HI 26
`define F_WC_LO 15

`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_COUNTER 12'h008
`define OFF_OPADDR 12'h00C
`define OFF_AR1 12'h010
`define OFF_AR2 12'h014
`define OFF_AR4 12'h018
`define OFF_AR8 12'h01C
`define OFF_INDEX_PAGE 6'h01
`define STATUS_OVF_BIT 4
`define CTRL_RST 5'h00

`endif

//--- inc/mas_pkg.sv
// Types shared by the memory access sequencer and its helpers.
// No surroundings assumed.
package mas_pkg;
  typedef logic [26:0] word_t;
  typedef logic [14:0] addr_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_IND = 4'h4,
    ST_EXEC = 4'h8
  } cpu_state_t;
  typedef enum logic [4:0] {
    AC_NONE = 5'h01,
    AC_CPU = 5'h02,
    AC_CHRD = 5'h04,
    AC_CHCW = 5'h08,
    AC_CHWR = 5'h10
  } acc_t;
endpackage

//--- inc/mas_links.sv
// Links between the sequencer and its arbiter and nibble stager.
// Assumes all parties share one clock.
`timescale 1ns/1ps
interface arb_if #(parameter int N = 13) ();
  localparam int IW = $clog2(N);
  logic [N-1:0] req;
  logic take;
  logic any;
  logic [IW-1:0] idx;
  modport arbiter (input req, input take, output any, output idx);
  modport user (output req, output take, input any, input idx);
endinterface

interface stage_if ();
  logic [3:0] nib_in;
  logic nib_in_valid;
  logic [26:0] wr_word;
  logic wr_full;
  logic wr_take;
  logic [26:0] rd_word;
  logic rd_load;
  logic [3:0] nib_out;
  logic nib_out_valid;
  modport stager (input nib_in, input nib_in_valid, output wr_word, output wr_full, input wr_take,
                  input rd_word, input rd_load, output nib_out, output nib_out_valid);
  modport user (output nib_in, output nib_in_valid, input wr_word, input wr_full, output wr_take,
                output rd_word, output rd_load, input nib_out, input nib_out_valid);
endinterface

//--- rtl/channel_arbiter.sv
// Fixed-priority channel request latch; lowest index wins.
// Assumes requests are one-cycle pulses on the sequencer clock.
`timescale 1ns/1ps
`include "mas_params.svh"
module channel_arbiter #(
  parameter int NUM_CH = `NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  arb_if.arbiter a
);
  logic [NUM_CH-1:0] pending_q;
  logic [NUM_CH-1:0] grant_oh;

  always_comb begin
    grant_oh = '0;
    a.idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        grant_oh = NUM_CH'(1) << i;
        a.idx = $bits(a.idx)'(i);
      end
    end
  end

  assign a.any = |pending_q;

  // New request wins over the clear of a grant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= '0;
    end else begin
      pending_q <= (pending_q & ~(a.take ? grant_oh : '0)) | a.req;
    end
  end
endmodule

//--- rtl/nibble_stager.sv
// Write staging word gathered from nibbles, output staging word sent as nibbles.
// Assumes least significant nibble first, one nibble per clock.
`timescale 1ns/1ps
`include "mas_params.svh"
module nibble_stager (
  input wire logic pclk,
  input wire logic presetn,
  stage_if.stager s
);
  logic [27:0] acc_q;
  logic [2:0] in_cnt_q;
  logic full_q;
  logic [27:0] out_q;
  logic [2:0] out_cnt_q;
  logic [3:0] nib_q;
  logic nib_valid_q;

  assign s.wr_word = acc_q[26:0];
  assign s.wr_full = full_q;
  assign s.nib_out = nib_q;
  assign s.nib_out_valid = nib_valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      in_cnt_q <= '0;
      full_q <= 1'b0;
    end else if (s.wr_take) begin
      in_cnt_q <= '0;
      full_q <= 1'b0;
    end else if (s.nib_in_valid && !full_q) begin
      acc_q <= {s.nib_in, acc_q[27:4]};
      in_cnt_q <= in_cnt_q + 3'h1;
      full_q <= (in_cnt_q == 3'(`NIBS_PER_WORD - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      out_cnt_q <= '0;
      nib_q <= '0;
      nib_valid_q <= 1'b0;
    end else if (s.rd_load) begin
      out_q <= {1'b0, s.rd_word};
      out_cnt_q <= 3'(`NIBS_PER_WORD);
      nib_valid_q <= 1'b0;
    end else if (out_cnt_q != 3'h0) begin
      nib_q <= out_q[3:0];
      out_q <= out_q >> 4;
      out_cnt_q <= out_cnt_q - 3'h1;
      nib_valid_q <= 1'b1;
    end else begin
      nib_valid_q <= 1'b0;
    end
  end

  out_burst_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.rd_load |=> !s.nib_out_valid ##1 s.nib_out_valid[*7] ##1 !s.nib_out_valid)
    else $error("output staging did not send seven nibbles");
endmodule

//--- rtl/memory_access_sequencer.sv
// Memory access sequencer: channel arbitration, set-up, indirect and execution cycles.
// Assumes core memory holds read data valid by the next memory cycle boundary.
//
// Function
// - Every memory write passes a write staging word gathered from nibbles.
// - Every channel data read leaves through nibble output staging; control word fetches load the tape control word register.
// - Granted tape channel with control words: count minus one, address plus one.
// - Empty control word count fetches the next control word via channel counter.
// - Each memory cycle grants the lowest-index pending channel, then clears it.
// - Processor addresses use memory only with no channel request pending.
// - Priority: fast tape, slow tape, general channels, operands, instructions.
// - Last execution cycle: counter plus one, two or branch target.
// - Set-up cycle latches the instruction word into the operand register.
// - Set-up forms indexed address into select and operand address registers.
// - Execution cycle moves the operand into the alerted arithmetic registers.
// - Multi-word operands decrement operand address; counter waits for last word.
// - Index plus ten-bit address, fifteen-bit result, carry dropped.
// - Index select zero means no indexing.
// - Bits 11 to 14 select arithmetic registers one, two, four, eight.
// - Lowest selected register takes the word at the effective address.
// - Least significant word sign goes into every involved register.
// - Carry past the top selected register sets overflow and contingency.
// - One extra memory cycle per operand word beyond the first.
// - Instruction bit 25 makes the address point to an indirect word.
// - Each indirect word costs a cycle; counter unchanged; repeats on bit 25.
// - Nonzero bits 16 to 20 mark a field select word.
// - A granted channel's counter is incremented through the adder unless its tape control word is stepped instead.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mas_params.svh"
module memory_access_sequencer #(
  parameter int NUM_CH = `NUM_CH,
  parameter int NUM_CW = `NUM_CW,
  parameter int MEM_CYCLE_CLKS = `MEM_CYCLE_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mas_pkg::addr_t mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output mas_pkg::word_t mem_wdata,
  input wire mas_pkg::word_t mem_rdata,
  input wire logic [NUM_CH-1:0] chan_req,
  input wire logic [NUM_CH-1:0] chan_to_mem,
  input wire logic [3:0] nib_in,
  input wire logic nib_in_valid,
  output logic [3:0] nib_out,
  output logic nib_out_valid,
  output logic wr_stage_full,
  input wire logic exec_branch,
  input wire mas_pkg::addr_t exec_branch_addr,
  input wire logic exec_skip,
  input wire logic arith_carry_out,
  output logic overflow,
  output logic contingency
);
  import mas_pkg::*;

  localparam int CNTW = $clog2(MEM_CYCLE_CLKS);
  localparam int CWW = (NUM_CW > 1) ? $clog2(NUM_CW) : 1;
  localparam int IW = $clog2(NUM_CH);

  generate
    if (NUM_CW < 1 || NUM_CW > NUM_CH || NUM_CH > 16 || MEM_CYCLE_CLKS < 2) begin : g_bad
      $error("memory_access_sequencer: unsupported parameters");
    end
  endgenerate

  arb_if #(.N(NUM_CH)) arb ();
  stage_if stg ();

  logic [CNTW-1:0] cyc_q;
  logic tick;
  logic run_q;
  logic [NUM_CW-1:0] cw_en_q;
  logic overflow_q;
  logic contingency_q;
  cpu_state_t st_q;
  acc_t last_q;
  logic [IW-1:0] last_ch_q;
  addr_t memory_select_register_q;
  addr_t operand_address_register_q;
  addr_t instruction_counter_q;
  word_t central_operand_register_q;
  word_t arith_reg_q [4];
  addr_t index_reg_q [16];
  addr_t channel_address_counter_q [NUM_CH];
  word_t tape_control_word_register_q [NUM_CW];
  logic [3:0] rem_q;
  logic [3:0] sel_q;
  logic first_q;
  logic ls_sign_q;
  logic mem_rd_q;
  logic mem_wr_q;
  word_t mem_wdata_q;
  logic wr_take_q;
  logic rd_load_q;
  word_t rd_word_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  word_t cpu_word;
  logic [3:0] ix;
  addr_t ix_val;
  addr_t ea_short;
  addr_t ea_long;
  logic is_fs;
  logic [3:0] low_ar;
  logic last_word;
  logic sign_all;
  logic [IW-1:0] g;
  logic [CWW-1:0] g_cw;
  logic cw_path;
  logic use_tcw;
  word_t tcw_cur;
  addr_t chan_addr;
  addr_t cc_next;
  logic apb_acc;
  logic apb_wr;
  logic dec_err;
  logic [31:0] rd_val;

  channel_arbiter #(.NUM_CH(NUM_CH)) u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .a(arb)
  );

  nibble_stager u_stage (
    .pclk(pclk),
    .presetn(presetn),
    .s(stg)
  );

  assign arb.req = chan_req;
  assign arb.take = tick;
  assign stg.nib_in = nib_in;
  assign stg.nib_in_valid = nib_in_valid;
  assign stg.wr_take = wr_take_q;
  assign stg.rd_word = rd_word_q;
  assign stg.rd_load = rd_load_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_addr = memory_select_register_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = mem_wdata_q;
  assign nib_out = stg.nib_out;
  assign nib_out_valid = stg.nib_out_valid;
  assign wr_stage_full = stg.wr_full;
  assign overflow = overflow_q;
  assign contingency = contingency_q;

  // Memory cycle boundary
  assign tick = (cyc_q == CNTW'(MEM_CYCLE_CLKS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= tick ? '0 : cyc_q + CNTW'(1);
    end
  end

  always_comb begin
    cpu_word = (last_q == AC_CPU) ? mem_rdata : central_operand_register_q;
    ix = cpu_word[`F_IX_HI:`F_IX_LO];
    ix_val = (ix == 4'h0) ? '0 : index_reg_q[ix];
    ea_short = ix_val + addr_t'(cpu_word[`F_M_HI:0]);
    ea_long = ix_val + cpu_word[14:0];
    is_fs = (cpu_word[`F_FS_HI:`F_FS_LO] != 5'h0);
    low_ar = rem_q & (~rem_q + 4'h1);
    last_word = ((rem_q & (rem_q - 4'h1)) == 4'h0);
    sign_all = first_q ? cpu_word[`F_SIGN] : ls_sign_q;
    g = arb.idx;
    g_cw = CWW'(g);
    cw_path = (int'(g) < NUM_CW) && cw_en_q[g_cw];
    tcw_cur = tape_control_word_register_q[g_cw];
    use_tcw = cw_path && (tcw_cur[`F_WC_HI:`F_WC_LO] != 12'h0);
    chan_addr = channel_address_counter_q[g];
    cc_next = exec_branch ? exec_branch_addr : instruction_counter_q + (exec_skip ? 15'h2 : 15'h1);
  end

  // One source per memory cycle: channels first, then the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      last_q <= AC_NONE;
      last_ch_q <= '0;
      memory_select_register_q <= '0;
      operand_address_register_q <= '0;
      instruction_counter_q <= '0;
      central_operand_register_q <= '0;
      arith_reg_q <= '{default: '0};
      channel_address_counter_q <= '{default: '0};
      tape_control_word_register_q <= '{default: '0};
      rem_q <= '0;
      sel_q <= '0;
      first_q <= 1'b0;
      ls_sign_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= '0;
      wr_take_q <= 1'b0;
      rd_load_q <= 1'b0;
      rd_word_q <= '0;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      wr_take_q <= 1'b0;
      rd_load_q <= 1'b0;
      if (apb_wr && paddr == `OFF_COUNTER) begin
        instruction_counter_q <= pwdata[14:0];
      end
      if (tick) begin
        if (last_q == AC_CPU) begin
          central_operand_register_q <= mem_rdata;
        end
        if (last_q == AC_CHCW) begin
          tape_control_word_register_q[CWW'(last_ch_q)] <= mem_rdata;
        end
        if (last_q == AC_CHRD) begin
          rd_word_q <= mem_rdata;
          rd_load_q <= 1'b1;
        end
        last_q <= AC_NONE;
        if (arb.any) begin
          last_ch_q <= g;
          if (use_tcw) begin
            memory_select_register_q <= tcw_cur[14:0] + 15'h1;
            tape_control_word_register_q[g_cw] <= {tcw_cur[`F_WC_HI:`F_WC_LO] - 12'h1, tcw_cur[14:0] + 15'h1};
          end else begin
            memory_select_register_q <= chan_addr + 15'h1;
            channel_address_counter_q[g] <= chan_addr + 15'h1;
          end
          if (cw_path && !use_tcw) begin
            mem_rd_q <= 1'b1;
            last_q <= AC_CHCW;
          end else if (chan_to_mem[g]) begin
            mem_wr_q <= 1'b1;
            mem_wdata_q <= stg.wr_word;
            wr_take_q <= 1'b1;
            last_q <= AC_CHWR;
          end else begin
            mem_rd_q <= 1'b1;
            last_q <= AC_CHRD;
          end
        end else if (run_q) begin
          mem_rd_q <= 1'b1;
          last_q <= AC_CPU;
          unique case (st_q)
            ST_IDLE: begin
              memory_select_register_q <= instruction_counter_q;
              st_q <= ST_SETUP;
            end
            ST_SETUP: begin
              memory_select_register_q <= ea_short;
              operand_address_register_q <= ea_short;
              rem_q <= cpu_word[`F_AR_HI:`F_AR_LO];
              sel_q <= cpu_word[`F_AR_HI:`F_AR_LO];
              first_q <= 1'b1;
              st_q <= cpu_word[`F_IND] ? ST_IND : ST_EXEC;
            end
            ST_IND: begin
              memory_select_register_q <= is_fs ? ea_short : ea_long;
              operand_address_register_q <= is_fs ? ea_short : ea_long;
              st_q <= (!is_fs && cpu_word[`F_IND]) ? ST_IND : ST_EXEC;
            end
            ST_EXEC: begin
              for (int k = 0; k < 4; k++) begin
                if (low_ar[k]) begin
                  arith_reg_q[k] <= cpu_word;
                end
              end
              if (first_q) begin
                ls_sign_q <= cpu_word[`F_SIGN];
              end
              first_q <= 1'b0;
              rem_q <= rem_q & ~low_ar;
              if (!last_word) begin
                memory_select_register_q <= operand_address_register_q - 15'h1;
                operand_address_register_q <= operand_address_register_q - 15'h1;
              end else begin
                memory_select_register_q <= cc_next;
                instruction_counter_q <= cc_next;
                st_q <= ST_SETUP;
                for (int k = 0; k < 4; k++) begin
                  if (sel_q[k]) begin
                    arith_reg_q[k][`F_SIGN] <= sign_all;
                  end
                end
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Overflow is sticky until software writes one to its status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
      contingency_q <= 1'b0;
    end else begin
      overflow_q <= (overflow_q & ~(apb_wr && paddr == `OFF_STATUS && pwdata[`STATUS_OVF_BIT]))
                    | arith_carry_out;
      contingency_q <= arith_carry_out;
    end
  end

  // Register bus
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pready_q && pwrite && !pslverr_q;

  always_comb begin
    rd_val = '0;
    dec_err = 1'b0;
    if (paddr[11:6] == `OFF_INDEX_PAGE && paddr[1:0] == 2'b00) begin
      rd_val = 32'(index_reg_q[paddr[5:2]]);
    end else begin
      case (paddr)
        `OFF_CTRL: rd_val = 32'({cw_en_q, run_q});
        `OFF_STATUS: rd_val = 32'({stg.wr_full, overflow_q, st_q});
        `OFF_COUNTER: rd_val = 32'(instruction_counter_q);
        `OFF_OPADDR: rd_val = 32'(operand_address_register_q);
        `OFF_AR1: rd_val = 32'(arith_reg_q[0]);
        `OFF_AR2: rd_val = 32'(arith_reg_q[1]);
        `OFF_AR4: rd_val = 32'(arith_reg_q[2]);
        `OFF_AR8: rd_val = 32'(arith_reg_q[3]);
        default: dec_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_acc && !pready_q;
      if (apb_acc && !pready_q) begin
        prdata_q <= pwrite ? '0 : rd_val;
        pslverr_q <= dec_err;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cw_en_q, run_q} <= (NUM_CW + 1)'(`CTRL_RST);
    end else if (apb_wr && paddr == `OFF_CTRL) begin
      {cw_en_q, run_q} <= pwdata[NUM_CW:0];
    end
  end

  // Entry zero is never written and reads as no indexing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_reg_q <= '{default: '0};
    end else if (apb_wr && paddr[11:6] == `OFF_INDEX_PAGE && paddr[5:2] != 4'h0) begin
      index_reg_q[paddr[5:2]] <= pwdata[14:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cpu(cpu_state_t s);
    tick && !arb.any && run_q && st_q == s;
  endsequence

  sequence s_chan;
    tick && arb.any;
  endsequence

  chan_first_a: assert property (s_chan |=> $stable(st_q) && last_q != AC_CPU)
    else $error("processor used a cycle while a channel was pending");
  one_source_a: assert property ((mem_rd_q || mem_wr_q) |-> !(mem_rd_q && mem_wr_q) && $past(tick))
    else $error("two accesses or access off the cycle boundary");
  chan_addr_a: assert property ((s_chan and !use_tcw) |=> memory_select_register_q == $past(chan_addr) + 15'h1)
    else $error("channel counter not incremented into select register");
  tcw_step_a: assert property ((s_chan and use_tcw) |=>
    memory_select_register_q == $past(tcw_cur[14:0]) + 15'h1 &&
    tape_control_word_register_q[$past(g_cw)][`F_WC_HI:`F_WC_LO] == $past(tcw_cur[`F_WC_HI:`F_WC_LO]) - 12'h1)
    else $error("tape control word not stepped");
  index_ea_a: assert property (s_cpu(ST_SETUP) |=>
    operand_address_register_q == $past(ea_short) && memory_select_register_q == operand_address_register_q)
    else $error("effective address not loaded");
  no_index_a: assert property ((s_cpu(ST_SETUP) and (ix == 4'h0)) |=>
    operand_address_register_q == addr_t'($past(cpu_word[`F_M_HI:0])))
    else $error("index zero modified the address");
  indirect_cc_a: assert property ((s_cpu(ST_IND) and !apb_wr) |=> $stable(instruction_counter_q))
    else $error("indirect cycle changed the counter");
  multi_dec_a: assert property ((s_cpu(ST_EXEC) and (!last_word && !apb_wr)) |=>
    operand_address_register_q == $past(operand_address_register_q) - 15'h1 && $stable(instruction_counter_q))
    else $error("multi-word step wrong");
  cc_step_a: assert property ((s_cpu(ST_EXEC) and (last_word && !exec_branch && !exec_skip)) |=>
    instruction_counter_q == $past(instruction_counter_q) + 15'h1 && memory_select_register_q == instruction_counter_q)
    else $error("counter not advanced by one");
  wr_path_a: assert property ((s_chan and (!cw_path && chan_to_mem[g])) |=>
    mem_wr_q && mem_wdata_q == $past(stg.wr_word) ##1 !stg.wr_full)
    else $error("write did not use the staging word");
  sign_fill_a: assert property ((s_cpu(ST_EXEC) and (last_word && sel_q[3])) |=>
    arith_reg_q[3][`F_SIGN] == $past(sign_all))
    else $error("operand sign not spread");
endmodule

//--- verif/core_mem_model.sv
// Core memory model behind the sequencer's address and strobes.
// Assumes one clock; read data lands LAT clocks after the read strobe.
`timescale 1ns/1ps
module core_mem_model #(
  parameter int LAT = 1
) (
  input wire logic pclk,
  input wire mas_pkg::addr_t mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire mas_pkg::word_t mem_wdata,
  output mas_pkg::word_t mem_rdata
);
  import mas_pkg::*;
  word_t mem [0:255];
  int cnt = 0;
  addr_t a = '0;
  initial begin
    mem_rdata = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  // Stale data shows inverted until the access time has run
  always @(posedge pclk) begin
    if (mem_wr === 1'b1) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd === 1'b1) begin
      a <= mem_addr;
      cnt <= LAT;
      mem_rdata <= ~mem_rdata;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) mem_rdata <= mem[a[7:0]];
    end
  end
endmodule

//--- verif/memory_access_sequencer_tb.sv
// Bench for the memory access sequencer: APB, channel and processor cycles.
// Assumes the core memory model and a shortened memory cycle.
`timescale 1ns/1ps
module memory_access_sequencer_tb;
  import mas_pkg::*;
  localparam int MC = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, seed = 32'h0000_002F;
  logic pready, pslverr, mem_rd, mem_wr, nib_out_valid, wr_stage_full, overflow, contingency;
  logic [12:0] chan_req = '0, chan_to_mem = '0;
  logic [3:0] nib_in = '0, nib_out, xi;
  logic nib_in_valid = 0, exec_branch = 0, exec_skip = 0, arith_carry_out = 0;
  addr_t mem_addr, exec_branch_addr = '0, pc, xv;
  word_t mem_wdata, mem_rdata, w, v;
  logic [27:0] g;
  logic [9:0] m;
  logic [1:0] sb;
  int fail_count = 0, total_checks = 0;
  logic [15:0] log_q[$];
  logic [3:0] nib_q[$];
  addr_t x[$];
  initial forever #2.5 pclk = ~pclk;
  memory_access_sequencer #(.MEM_CYCLE_CLKS(MC)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .chan_req,
    .chan_to_mem, .nib_in, .nib_in_valid, .nib_out, .nib_out_valid, .wr_stage_full, .exec_branch,
    .exec_branch_addr, .exec_skip, .arith_carry_out, .overflow, .contingency);
  core_mem_model #(.LAT(4)) mem_u (.pclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  always @(posedge pclk) begin
    if (mem_rd === 1'b1 || mem_wr === 1'b1) log_q.push_back({mem_wr, mem_addr});
    if (nib_out_valid === 1'b1) nib_q.push_back(nib_out);
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic word_t mk(input logic i, input logic [3:0] x, input logic [3:0] ar, input logic [9:0] a);
    return {2'b00, i, x, 6'h00, ar, a};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic die();
    fail_count++;
    print_verdict();
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) die();
    tick(1);
  endtask
  task automatic wait_q(input int k, input bit nib);
    int n;
    n = 0;
    while ((nib ? nib_q.size() : log_q.size()) < k && n < 50 * MC) begin
      tick(1);
      n++;
    end
    if (n == 50 * MC) die();
  endtask
  task automatic rst();
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    tick(1);
  endtask
  task automatic run(input word_t ins, input addr_t p, input logic [3:0] i, input addr_t xr, input addr_t il,
                     input word_t iw, input logic [1:0] s);
    rst();
    mem_u.mem[p[7:0]] = ins;
    if (il != 0) mem_u.mem[il[7:0]] = iw;
    apb({6'h01, i, 2'b00}, 1'b1, 32'(xr));
    apb(12'h008, 1'b1, 32'(p));
    exec_skip <= s[0];
    exec_branch <= s[1];
    exec_branch_addr <= 15'h1234;
    log_q.delete();
    apb(12'h000, 1'b1, 32'h0000_0001);
    wait_q(x.size(), 0);
    foreach (x[k]) chk("access", 32'(x[k]), 32'(log_q[k]));
  endtask
  initial begin
    rst();
    apb(12'h004, 1'b0, '0);
    chk("status", 32'h0000_0001, r);
    apb(12'h0F0, 1'b1, 32'hFFFF_FFFF);
    chk("slverr", 32'h0000_0001, 32'(e));
    w = 27'(rnd());
    v = 27'(rnd());
    mem_u.mem[1] = v;
    for (int k = 0; k < 7; k++) begin
      nib_in <= 4'({1'b0, w} >> (4 * k));
      nib_in_valid <= 1'b1;
      tick(1);
    end
    nib_in_valid <= 1'b0;
    tick(1);
    chk("full", 32'h0000_0001, 32'(wr_stage_full));
    log_q.delete();
    chan_to_mem <= 13'h0080;
    chan_req <= 13'h0088;
    tick(1);
    chan_req <= '0;
    wait_q(2, 0);
    chk("grant_rd", 32'h0000_0001, 32'(log_q[0]));
    chk("grant_wr", 32'h0000_8001, 32'(log_q[1]));
    wait_q(7, 1);
    foreach (nib_q[k]) if (k < 7) g[4 * k +: 4] = nib_q[k];
    chk("nibbles", 32'(v), 32'(g));
    chk("written", 32'(w), 32'(mem_u.mem[1]));
    chk("full_clr", 32'h0, 32'(wr_stage_full));
    apb(12'h000, 1'b1, 32'h0000_0002);
    mem_u.mem[1] = {12'h002, 15'h0050};
    x = '{15'h0001, 15'h0051, 15'h0052, 15'h0002};
    log_q.delete();
    foreach (x[i]) begin
      chan_req <= 13'h0001;
      tick(1);
      chan_req <= '0;
      wait_q(i + 1, 0);
      tick(2 * MC);
      chk("tape", 32'(x[i]), 32'(log_q[i]));
    end
    arith_carry_out <= 1'b1;
    tick(1);
    arith_carry_out <= 1'b0;
    tick(1);
    chk("contingency", 32'h0000_0001, 32'(contingency));
    chk("overflow_pin", 32'h0000_0001, 32'(overflow));
    apb(12'h004, 1'b0, '0);
    chk("overflow", 32'h0000_0010, r & 32'h0000_0010);
    apb(12'h004, 1'b1, 32'h0000_0010);
    apb(12'h004, 1'b0, '0);
    chk("ovf_clear", 32'h0, r & 32'h0000_0010);
    chk("ovf_pin_clear", 32'h0, 32'(overflow));
    x = '{15'h0020, 15'h03FF, 15'h1234};
    run(mk(1'b0, 4'h0, 4'b0100, 10'h3FF), 15'h0020, 4'h0, 15'h7777, '0, '0, 2'b10);
    x = '{15'h0030, 15'h0010, 15'h0031};
    run(mk(1'b0, 4'h5, 4'b1000, 10'h020), 15'h0030, 4'h5, 15'h7FF0, '0, '0, 2'b00);
    x = '{15'h0010, 15'h0070, 15'h0056, 15'h0011};
    run(mk(1'b1, 4'h0, 4'b0001, 10'h070), 15'h0010, 4'h2, 15'h0005, 15'h0070, {7'h02, 5'h00, 15'h0051}, 2'b00);
    x = '{15'h0012, 15'h0072, 15'h0055, 15'h0013};
    run(mk(1'b1, 4'h0, 4'b0001, 10'h072), 15'h0012, 4'h0, '0, 15'h0072, {7'h10, 5'h03, 15'h0C55}, 2'b00);
    for (int k = 0; k < 3; k++) mem_u.mem[8'h7E + k] = 27'(rnd() & 32'h00FF_FFFF);
    mem_u.mem[8'h80][24] = 1'b1;
    for (int k = 1; k < 4; k++) mem_u.mem[8'h40 + k] = '0;
    x = '{15'h0040, 15'h0080, 15'h007F, 15'h007E, 15'h0041};
    run(mk(1'b0, 4'h0, 4'b1011, 10'h080), 15'h0040, 4'h0, '0, '0, '0, 2'b00);
    tick(MC);
    apb(12'h010, 1'b0, '0);
    chk("ar1", 32'(mem_u.mem[8'h80]), r);
    apb(12'h014, 1'b0, '0);
    chk("ar2", 32'(mem_u.mem[8'h7F]) | 32'h0100_0000, r);
    apb(12'h01C, 1'b0, '0);
    chk("ar8", 32'(mem_u.mem[8'h7E]) | 32'h0100_0000, r);
    apb(12'h018, 1'b0, '0);
    chk("ar4", 32'h0, r);
    for (int k = 0; k < 4; k++) begin
      pc = 15'(rnd());
      xv = 15'(rnd());
      m = 10'(rnd());
      xi = 4'(rnd() % 15 + 1);
      sb = 2'(rnd() & 1);
      x = '{pc, xv + 15'(m), pc + 15'd1 + 15'(sb[0])};
      run(mk(1'b0, xi, 4'b0001 << (rnd() % 4), m), pc, xi, xv, '0, '0, sb);
    end
    print_verdict();
  end
endmodule
